/* File: inc/fssc_pkg.sv */
// Constants and types for the fieldbus slave status and configuration block.
// Assumes a 100 MHz system clock and a 32-bit register port with byte offsets.
package fssc_pkg;

  // ==========================================================
  // Clock
  localparam int unsigned CLK_PERIOD_NS = 10;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_STATE     = 8'h00;
  localparam logic [7:0] OFS_FAULT     = 8'h04;
  localparam logic [7:0] OFS_ADDR_MODE = 8'h08;
  localparam logic [7:0] OFS_NODE      = 8'h0c;
  localparam logic [7:0] OFS_WORDS     = 8'h10;
  localparam logic [7:0] OFS_REFRESH   = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h1c;

  // ==========================================================
  // Field positions
  localparam int FLT_CFG   = 0;
  localparam int FLT_SYNC  = 1;
  localparam int FLT_WDT   = 2;
  localparam int FLT_BOOT  = 3;
  localparam int FLT_W     = 4;
  localparam int NODE_VAL  = 8;
  localparam int NODE_USED = 9;
  localparam int NODE_BAD  = 10;
  localparam int IRQ_ADDR  = 0;
  localparam int IRQ_REFR  = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_W     = 3;

  // ==========================================================
  // Reset values
  localparam logic [FLT_W-1:0] FAULT_RST = 4'h0;
  localparam logic [IRQ_W-1:0] MASK_RST  = 3'h0;
  localparam logic             MODE_RST  = 1'b0;
  localparam logic [7:0]       WORDS_RST = 8'h00;

  // ==========================================================
  // Refresh timing
  localparam int unsigned T_REFR_62_NS  = 62500;
  localparam int unsigned T_REFR_125_NS = 125000;
  localparam int unsigned T_REFR_250_NS = 250000;
  localparam int unsigned T_REFR_500_NS = 500000;
  localparam int unsigned REFR_62_CYC   = T_REFR_62_NS / CLK_PERIOD_NS;
  localparam int unsigned REFR_125_CYC  = T_REFR_125_NS / CLK_PERIOD_NS;
  localparam int unsigned REFR_250_CYC  = T_REFR_250_NS / CLK_PERIOD_NS;
  localparam int unsigned REFR_500_CYC  = T_REFR_500_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  WORDS_62_MAX  = 8'd22;
  localparam logic [7:0]  WORDS_125_MAX = 8'd44;
  localparam logic [7:0]  WORDS_250_MAX = 8'd88;
  localparam logic [7:0]  WORDS_500_MAX = 8'd176;
  localparam logic [1:0]  DIP_AUTO      = 2'h1;

  // ==========================================================
  // Indicator timing
  localparam int unsigned T_FLICK_NS      = 50000000;
  localparam int unsigned FLICK_CYC       = T_FLICK_NS / CLK_PERIOD_NS;
  localparam logic [1:0]  FLICKS_PER_SLOT = 2'h3;
  localparam logic [2:0]  SLOT_LAST       = 3'h5;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP} fssc_state_e;
  typedef enum logic [1:0] {RF_62, RF_125, RF_250, RF_500} fssc_refresh_e;

endpackage : fssc_pkg

/* File: rtl/fssc_top.sv */
// Status indicators, station switch decode and refresh timing of a fieldbus slave.
// Assumes switches are synchronous to mclk and a register master per the plain port.
module fssc_top #(
  parameter int unsigned FLICK_CYC = fssc_pkg::FLICK_CYC,
  parameter int unsigned R62_CYC   = fssc_pkg::REFR_62_CYC,
  parameter int unsigned R125_CYC  = fssc_pkg::REFR_125_CYC,
  parameter int unsigned R250_CYC  = fssc_pkg::REFR_250_CYC,
  parameter int unsigned R500_CYC  = fssc_pkg::REFR_500_CYC
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Switches
  input  wire logic [3:0]  rot_tens,
  input  wire logic [3:0]  rot_ones,
  input  wire logic [1:0]  dip_refresh,
  // Indicators
  output logic             run_led,
  output logic             err_led,
  // Node address and refresh
  output logic [6:0]       node_addr,
  output logic             node_addr_valid,
  output logic             refresh_tick,
  // Interrupt
  output logic             irq
);

  // ==========================================================
  // Functions
  function automatic logic digit_ok(input logic [3:0] d);
    digit_ok = (d <= 4'h9);
  endfunction : digit_ok

  function automatic logic [6:0] station_value(input logic [3:0] t, input logic [3:0] o);
    logic [7:0] p;
    p = {4'h0, t} * 8'd10 + {4'h0, o};
    station_value = p[6:0];
  endfunction : station_value

  // Exact offset match; a partial decode would alias registers into unmapped space
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  // Out-of-range counts fall back to the slowest cycle, which is always safe
  function automatic fssc_pkg::fssc_refresh_e refresh_by_words(input logic [7:0] w);
    if (w == 8'h00 || w > fssc_pkg::WORDS_500_MAX) begin
      refresh_by_words = fssc_pkg::RF_500;
    end else if (w <= fssc_pkg::WORDS_62_MAX) begin
      refresh_by_words = fssc_pkg::RF_62;
    end else if (w <= fssc_pkg::WORDS_125_MAX) begin
      refresh_by_words = fssc_pkg::RF_125;
    end else if (w <= fssc_pkg::WORDS_250_MAX) begin
      refresh_by_words = fssc_pkg::RF_250;
    end else begin
      refresh_by_words = fssc_pkg::RF_500;
    end
  endfunction : refresh_by_words

  // ==========================================================
  // Registers
  // Slave state and faults arrive from the protocol engine as register writes
  fssc_pkg::fssc_state_e            slave_state;
  logic [fssc_pkg::FLT_W-1:0]       fault;
  logic                             fixed_mode;
  logic [7:0]                       words;
  logic [fssc_pkg::IRQ_W-1:0]       irq_stat;
  logic [fssc_pkg::IRQ_W-1:0]       irq_mask;

  // Writes to read-only or unmapped offsets match no decode and change nothing
  wire wr_state = wr && reg_hit(addr, fssc_pkg::OFS_STATE);
  wire wr_fault = wr && reg_hit(addr, fssc_pkg::OFS_FAULT);
  wire wr_mode  = wr && reg_hit(addr, fssc_pkg::OFS_ADDR_MODE);
  wire wr_words = wr && reg_hit(addr, fssc_pkg::OFS_WORDS);
  wire wr_istat = wr && reg_hit(addr, fssc_pkg::OFS_IRQ_STAT);
  wire wr_imask = wr && reg_hit(addr, fssc_pkg::OFS_IRQ_MASK);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      slave_state <= fssc_pkg::ST_INIT;
      fault       <= fssc_pkg::FAULT_RST;
      fixed_mode  <= fssc_pkg::MODE_RST;
      words       <= fssc_pkg::WORDS_RST;
      irq_mask    <= fssc_pkg::MASK_RST;
    end else begin
      if (wr_state) begin
        slave_state <= fssc_pkg::fssc_state_e'(wdata[1:0]);
      end
      if (wr_fault) begin
        fault <= wdata[fssc_pkg::FLT_W-1:0];
      end
      if (wr_mode) begin
        fixed_mode <= wdata[0];
      end
      if (wr_words) begin
        words <= wdata[7:0];
      end
      if (wr_imask) begin
        irq_mask <= wdata[fssc_pkg::IRQ_W-1:0];
      end
    end
  end

  // ==========================================================
  // Station switch decode
  wire [6:0] sw_value = station_value(rot_tens, rot_ones);
  wire       sw_valid = digit_ok(rot_tens) && digit_ok(rot_ones)
                        && sw_value != 7'h00;
  wire       addr_use = fixed_mode && sw_valid;
  // Only flagged under fixed addressing; other methods expect the switch at zero
  wire       addr_bad = fixed_mode && !sw_valid;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      node_addr       <= 7'h00;
      node_addr_valid <= 1'b0;
    end else begin
      node_addr       <= addr_use ? sw_value : 7'h00;
      node_addr_valid <= addr_use;
    end
  end

  // ==========================================================
  // Refresh cycle
  wire fssc_pkg::fssc_refresh_e refr_sel =
    (dip_refresh == fssc_pkg::DIP_AUTO) ? refresh_by_words(words)
                                        : fssc_pkg::RF_500;

  logic [15:0] refr_period;
  always_comb begin
    case (refr_sel)
      fssc_pkg::RF_62:  refr_period = 16'(R62_CYC);
      fssc_pkg::RF_125: refr_period = 16'(R125_CYC);
      fssc_pkg::RF_250: refr_period = 16'(R250_CYC);
      default:          refr_period = 16'(R500_CYC);
    endcase
  end

  // A shorter period selected mid-count wraps at once through the >= compare
  logic [15:0] refr_cnt;
  wire         refr_end = refr_cnt >= refr_period - 16'h0001;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      refr_cnt     <= 16'h0000;
      refresh_tick <= 1'b0;
    end else begin
      refr_cnt     <= refr_end ? 16'h0000 : refr_cnt + 16'h0001;
      refresh_tick <= refr_end;
    end
  end

  // ==========================================================
  // Indicator timebase
  // Free-running so both indicators stay in step with one another
  logic [22:0] flick_cnt;
  logic [1:0]  sub_cnt;
  logic [2:0]  slot;
  logic        flick_ph;

  wire flick_tick = flick_cnt == 23'(FLICK_CYC - 1);
  wire slot_tick  = flick_tick && sub_cnt == fssc_pkg::FLICKS_PER_SLOT;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flick_cnt <= 23'h000000;
      sub_cnt   <= 2'h0;
      slot      <= 3'h0;
      flick_ph  <= 1'b0;
    end else begin
      flick_cnt <= flick_tick ? 23'h000000 : flick_cnt + 23'h000001;
      if (flick_tick) begin
        flick_ph <= !flick_ph;
        sub_cnt  <= sub_cnt + 2'h1;
      end
      if (slot_tick) begin
        slot <= (slot == fssc_pkg::SLOT_LAST) ? 3'h0 : slot + 3'h1;
      end
    end
  end

  // Six slots per frame: blink alternates, flashes are one or two slots on
  wire pat_blink  = !slot[0];
  wire pat_single = slot == 3'h0;
  wire pat_double = slot == 3'h0 || slot == 3'h2;

  // ==========================================================
  // Indicators
  // Configuration error covers a bad switch under fixed addressing as well
  wire cfg_err = fault[fssc_pkg::FLT_CFG] || addr_bad;
  wire any_err = cfg_err || fault[fssc_pkg::FLT_SYNC]
                 || fault[fssc_pkg::FLT_WDT] || fault[fssc_pkg::FLT_BOOT];

  logic next_run_led;
  always_comb begin
    case (slave_state)
      fssc_pkg::ST_INIT:   next_run_led = 1'b0;
      fssc_pkg::ST_PREOP:  next_run_led = pat_blink;
      fssc_pkg::ST_SAFEOP: next_run_led = pat_single;
      fssc_pkg::ST_OP:     next_run_led = 1'b1;
      default:             next_run_led = 1'b0;
    endcase
  end

  // Most severe fault wins when several are present
  wire next_err_led =
    fault[fssc_pkg::FLT_BOOT] ? flick_ph :
    fault[fssc_pkg::FLT_WDT]  ? pat_double :
    fault[fssc_pkg::FLT_SYNC] ? pat_single :
    cfg_err                   ? pat_blink : 1'b0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_led <= 1'b0;
      err_led <= 1'b0;
    end else begin
      run_led <= next_run_led;
      err_led <= next_err_led;
    end
  end

  // ==========================================================
  // Interrupts
  // Edge detectors reset to their idle level so no false event follows reset
  logic                  addr_bad_q;
  logic                  any_err_q;
  fssc_pkg::fssc_refresh_e refr_sel_q;

  wire [fssc_pkg::IRQ_W-1:0] irq_ev = {any_err && !any_err_q,
                                       refr_sel != refr_sel_q,
                                       addr_bad && !addr_bad_q};
  wire [fssc_pkg::IRQ_W-1:0] irq_clr = wr_istat ? wdata[fssc_pkg::IRQ_W-1:0] : '0;
  // Set wins over a clear in the same cycle so no event is lost
  wire [fssc_pkg::IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_ev;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_bad_q <= 1'b0;
      any_err_q  <= 1'b0;
      refr_sel_q <= fssc_pkg::RF_500;
      irq_stat   <= '0;
      irq        <= 1'b0;
    end else begin
      addr_bad_q <= addr_bad;
      any_err_q  <= any_err;
      refr_sel_q <= refr_sel;
      irq_stat   <= next_irq_stat;
      irq        <= |(next_irq_stat & irq_mask);
    end
  end

  // ==========================================================
  // Read port
  // Read data is zero outside the cycle after a read, so a stale word never shows
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    case (addr)
      fssc_pkg::OFS_STATE:     rd_mux[1:0] = slave_state;
      fssc_pkg::OFS_FAULT:     rd_mux[fssc_pkg::FLT_W-1:0] = fault;
      fssc_pkg::OFS_ADDR_MODE: rd_mux[0] = fixed_mode;
      fssc_pkg::OFS_NODE: begin
        rd_mux[6:0]                 = sw_value;
        rd_mux[fssc_pkg::NODE_VAL]  = sw_valid;
        rd_mux[fssc_pkg::NODE_USED] = addr_use;
        rd_mux[fssc_pkg::NODE_BAD]  = addr_bad;
      end
      fssc_pkg::OFS_WORDS:     rd_mux[7:0] = words;
      fssc_pkg::OFS_REFRESH:   rd_mux[1:0] = refr_sel;
      fssc_pkg::OFS_IRQ_STAT:  rd_mux[fssc_pkg::IRQ_W-1:0] = irq_stat;
      fssc_pkg::OFS_IRQ_MASK:  rd_mux[fssc_pkg::IRQ_W-1:0] = irq_mask;
      default:                 rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= rd ? rd_mux : 32'h00000000;
    end
  end

endmodule : fssc_top

/* File: verification/fieldbus_slave_status_config_tb.sv */
// Self-checking bench for fssc_top with short sim timebases.
// Assumes fssc_master_model drives the register port.
module fieldbus_slave_status_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] FR = 32'd96;
  logic        mclk, rst, wr, rd, run_led, err_led, node_addr_valid, refresh_tick, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  rot_tens, rot_ones;
  logic [1:0]  dip_refresh;
  logic [6:0]  node_addr;
  int          fail_count, n_tests, i;
  fssc_top #(.FLICK_CYC(4), .R62_CYC(10), .R125_CYC(20), .R250_CYC(40), .R500_CYC(80)) DUT (.mclk(mclk),
    .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rot_tens(rot_tens),
    .rot_ones(rot_ones), .dip_refresh(dip_refresh), .run_led(run_led), .err_led(err_led), .node_addr(node_addr),
    .node_addr_valid(node_addr_valid), .refresh_tick(refresh_tick), .irq(irq));
  fssc_master_model m (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  always #5 mclk = ~mclk;
  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // Lit cycles over one whole frame; the window position does not matter
  task automatic lit(input logic err, input logic [31:0] exp);
    logic [31:0] n;
    n = 0;
    repeat (4) @(posedge mclk);
    repeat (96) begin
      @(posedge mclk);
      n = n + (err ? err_led : run_led);
    end
    chk(err ? "err lit" : "run lit", exp, n);
  endtask : lit
  task automatic tick_gap(output logic [31:0] n);
    n = 0;
    do begin
      @(posedge mclk);
      n = n + 1;
    end while (refresh_tick !== 1'b1 && n < 200);
    if (n >= 200) begin
      chk("tick wait", 1, 0);
      conclude();
    end
  endtask : tick_gap
  // First gap may straddle a selection change, so judge the second
  task automatic gap(input logic [31:0] exp);
    logic [31:0] n;
    tick_gap(n);
    tick_gap(n);
    chk("tick gap", exp, n);
  endtask : gap
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [7:0] O [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h1c};
    for (i = 0; i < 5; i++) begin
      m.get(O[i], d);
      chk("reset value", 32'h0, d);
    end
    m.put(8'h20, 32'hffffffff);
    m.get(8'h20, d);
    chk("unmapped", 32'h0, d);
    m.put(fssc_pkg::OFS_STATE, 32'hffffffff);
    m.get(fssc_pkg::OFS_STATE, d);
    chk("state width", 32'h3, d);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_irq();
    @(posedge mclk);
    dip_refresh <= 2'h1;
    m.put(fssc_pkg::OFS_WORDS, 32'h1);
    m.get(fssc_pkg::OFS_IRQ_STAT, d);
    chk("stat refresh", 32'h1, {31'h0, d[1]});
    chk("irq masked", 32'h0, {31'h0, irq});
    m.put(fssc_pkg::OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge mclk);
    chk("irq set", 32'h1, {31'h0, irq});
    m.put(fssc_pkg::OFS_IRQ_STAT, 32'h2);
    repeat (2) @(posedge mclk);
    chk("irq clear", 32'h0, {31'h0, irq});
    $display("t_irq done");
  endtask : t_irq
  task automatic t_station();
    logic [7:0] T [5] = '{8'h99, 8'h01, 8'h00, 8'ha0, 8'h47};
    logic [6:0] A [5] = '{7'd99, 7'd1, 7'd0, 7'd0, 7'd47};
    m.set_fixed(1'b1);
    for (i = 0; i < 5; i++) begin
      @(posedge mclk);
      {rot_tens, rot_ones} <= T[i];
      repeat (3) @(posedge mclk);
      chk("node addr", {25'h0, A[i]}, {25'h0, node_addr});
      chk("node valid", {31'h0, A[i] != 0}, {31'h0, node_addr_valid});
      m.get(fssc_pkg::OFS_NODE, d);
      chk("node bad", {31'h0, A[i] == 0}, {31'h0, d[10]});
      if (A[i] == 0) lit(1'b1, FR / 2);
    end
    m.set_fixed(1'b0);
    repeat (3) @(posedge mclk);
    chk("auto addr", 32'h0, {24'h0, node_addr_valid, node_addr});
    @(posedge mclk);
    {rot_tens, rot_ones} <= 8'ha0;
    lit(1'b1, 0);
    $display("t_station done");
  endtask : t_station
  task automatic t_leds();
    logic [31:0] R [4] = '{0, FR / 2, FR / 6, FR};
    logic [3:0]  F [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hc, 4'h6};
    logic [31:0] E [6] = '{0, FR / 2, FR / 6, FR / 3, FR / 2, FR / 3};
    for (i = 0; i < 4; i++) begin
      m.put(fssc_pkg::OFS_STATE, i);
      lit(1'b0, R[i]);
    end
    for (i = 0; i < 6; i++) begin
      m.put(fssc_pkg::OFS_FAULT, {28'h0, F[i]});
      lit(1'b1, E[i]);
    end
    m.put(fssc_pkg::OFS_FAULT, 32'h0);
    $display("t_leds done");
  endtask : t_leds
  task automatic t_refresh();
    logic [7:0] W [9] = '{8'd0, 8'd1, 8'd22, 8'd23, 8'd44, 8'd45, 8'd88, 8'd89, 8'd176};
    logic [1:0] C [9] = '{2'h3, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
    @(posedge mclk);
    dip_refresh <= 2'h0;
    gap(32'd80);
    @(posedge mclk);
    dip_refresh <= 2'h1;
    for (i = 0; i < 9; i++) begin
      m.put(fssc_pkg::OFS_WORDS, {24'h0, W[i]});
      m.get(fssc_pkg::OFS_REFRESH, d);
      chk("refresh sel", {30'h0, C[i]}, d);
      gap(32'd10 << C[i]);
    end
    // Position 2 on overrides the word count, so pick a count that would be fast
    m.put(fssc_pkg::OFS_WORDS, 32'h1);
    for (i = 2; i < 4; i++) begin
      @(posedge mclk);
      dip_refresh <= 2'(i);
      m.get(fssc_pkg::OFS_REFRESH, d);
      chk("refresh pos2", 32'h3, d);
      gap(32'd80);
    end
    $display("t_refresh done");
  endtask : t_refresh
  // ==========================================================
  // Main sequence
  initial begin
    mclk        = 1'b0;
    rst         = 1'b1;
    rot_tens    = 4'h0;
    rot_ones    = 4'h1;
    dip_refresh = 2'h0;
    fail_count  = 0;
    n_tests     = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_irq();
    t_station();
    t_leds();
    t_refresh();
    conclude();
  end
endmodule : fieldbus_slave_status_config_tb

/* File: verification/fssc_master_model.sv */
// Far-side master model: register accesses and the addressing method choice.
// Assumes its tasks are called from one bench process only.
module fssc_master_model (
  // Clock and read data
  input  wire logic        mclk,
  input  wire logic [31:0] rdata,
  // Register port
  output logic      [7:0]  addr,
  output logic      [31:0] wdata,
  output logic             wr,
  output logic             rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr  = 8'hff;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  // Idle bus shows inverted values so a stale address is never mistaken for a live one
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask : put
  task automatic get(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    addr <= ~a;
    @(posedge mclk);
    d = rdata;
  endtask : get
  task automatic set_fixed(input logic on);
    put(fssc_pkg::OFS_ADDR_MODE, {31'h0, on});
  endtask : set_fixed
endmodule : fssc_master_model

/* File: verification/fssc_top_asserts.sv */
// Port-level checker for fssc_top.
// Assumes the bench holds the switches steady for several cycles around each check.
module fssc_top_asserts #(
  parameter int unsigned R500_CYC = 80
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Register port
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // Switches and outputs
  input wire logic [3:0]  rot_tens,
  input wire logic [3:0]  rot_ones,
  input wire logic [1:0]  dip_refresh,
  input wire logic [6:0]  node_addr,
  input wire logic        node_addr_valid,
  input wire logic        refresh_tick,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Tick spacing counter; a period only counts once it began with the switches off
  int unsigned gap;
  logic        dip_off;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gap     <= 0;
      dip_off <= 1'b0;
    end else if (refresh_tick) begin
      gap     <= 0;
      dip_off <= (dip_refresh == 2'h0);
    end else begin
      gap     <= gap + 1;
      dip_off <= dip_off && (dip_refresh == 2'h0);
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rd_quiet; !$past(rd) |-> rdata == 32'h0; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
  property p_tick_pulse; refresh_tick |=> !refresh_tick; endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("refresh tick wider than a cycle");
  property p_range; node_addr_valid |-> node_addr inside {[7'd1:7'd99]}; endproperty
  a_range: assert property (p_range) else $error("station number out of range");
  property p_decode; node_addr_valid |-> node_addr == 7'($past(rot_tens) * 10 + $past(rot_ones)); endproperty
  a_decode: assert property (p_decode) else $error("station number decode wrong");
  property p_bad_sw; ($past(rot_tens) > 4'h9 || $past(rot_ones) > 4'h9 || {$past(rot_tens), $past(rot_ones)} == 8'h00) |-> !node_addr_valid; endproperty
  a_bad_sw: assert property (p_bad_sw) else $error("bad switch taken as address");
  property p_unused_zero; !node_addr_valid |-> node_addr == 7'h0; endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused switch value shown");
  property p_fixed_500; refresh_tick && dip_off && dip_refresh == 2'h0 |-> gap == R500_CYC - 1; endproperty
  a_fixed_500: assert property (p_fixed_500) else $error("fixed refresh period wrong");
  property p_irq_fall; $fell(irq) |-> $past(wr) || $past(wr, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without a write");
  c_valid: cover property (node_addr_valid);
  c_auto_tick: cover property (refresh_tick && dip_refresh == 2'h1);
  c_irq: cover property ($rose(irq));
endmodule : fssc_top_asserts

bind fssc_top fssc_top_asserts #(.R500_CYC(R500_CYC)) u_chk (.mclk(mclk), .rst(rst), .wr(wr), .rd(rd),
  .rdata(rdata), .rot_tens(rot_tens), .rot_ones(rot_ones), .dip_refresh(dip_refresh), .node_addr(node_addr),
  .node_addr_valid(node_addr_valid), .refresh_tick(refresh_tick), .irq(irq));
